/* File: rtl/cpu_zero_one_decode.v */
// Decode and execute of zero- and single-register instruction formats
// Function
// - Flag-clear sets the flag to zero, one state.
// - Flag-set sets the flag to one, one state.
// - Accumulator clear zeroes both halves, flag kept.
// - Unsigned divide init clears M, Q and flag.
// - No-operation takes one state, changes nothing.
// - Exception return pops PC and status word, four states.
// - Subroutine return branches to link register, two states.
// - Sleep entered three states after the op starts.
// - Compare-positive: flag when register signed above zero.
// - Compare-non-negative: flag when register signed zero or more.
// - Decrement-test: subtract one, flag when result zero.
// - Flag-to-register writes the flag into the register.
// - Plain rotates wrap outgoing bit, copy it to flag.
// - Flag rotates insert old flag, capture outgoing bit.
// - Arithmetic right shift keeps sign, outgoing bit to flag.
// - One-bit logical shifts fill zero, outgoing bit to flag.
// - Shifts by 2, 8 or 16 fill zero, keep flag.
// - Store opcodes copy a control or system register.
// - Indirect jump branches to register, two states.
// - Indirect call saves return in link, two states.
// - Byte test-and-set: flag if zero, set MSB, four states.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_decode_regs.vh"
module cpu_zero_one_decode (
  input wire REF_CLK,
  input wire RSTN,
  input wire INSTR_VALID,
  input wire [15:0] INSTR,
  input wire [31:0] INSTR_PC,
  output wire INSTR_READY,
  output wire BRANCH_VALID,
  output wire [31:0] BRANCH_TARGET,
  output wire SLEEP,
  output wire UNSUPPORTED,
  output wire T_FLAG,
  output wire MEM_REQ,
  output wire MEM_WE,
  output wire MEM_BYTE,
  output wire [31:0] MEM_ADDR,
  output wire [31:0] MEM_WDATA,
  input wire MEM_ACK,
  input wire [31:0] MEM_RDATA,
  input wire [4:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [4:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_WAIT = 3'd1;
  localparam [2:0] S_POP_PC = 3'd2;
  localparam [2:0] S_POP_SW = 3'd3;
  localparam [2:0] S_TAS_RD = 3'd4;
  localparam [2:0] S_TAS_WR = 3'd5;
  localparam [2:0] S_SLEEP = 3'd6;

  // Match a single-register opcode, ignoring the register field
  function is_n;
    input [15:0] op;
    input [3:0] grp;
    input [7:0] lo;
    begin
      is_n = (op[15:12] == grp) && (op[7:0] == lo);
    end
  endfunction

  // Byte-lane merge for register writes from the bus
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge[k*8 +: 8] = data[k*8 +: 8];
        end
      end
    end
  endfunction

  // ==========================================================
  // Core state
  reg [2:0] state_r;
  reg [1:0] cnt_r;
  reg ready_r;
  reg sleep_pend_r;
  reg sleep_r;
  reg br_valid_r;
  reg [31:0] br_target_r;
  reg unsup_r;
  reg [31:0] sw_r;
  reg [31:0] mul_acc_high_r;
  reg [31:0] mul_acc_low_r;
  reg [31:0] gbase_r;
  reg [31:0] vbase_r;
  reg [31:0] link_r;
  reg [31:0] ctrl_r;
  reg mem_req_r;
  reg mem_we_r;
  reg mem_byte_r;
  reg [31:0] mem_addr_r;
  reg [31:0] mem_wdata_r;
  reg [31:0] pop_pc_r;

  // ==========================================================
  // Decode
  wire accept = INSTR_VALID & ready_r;
  wire [3:0] dest = INSTR[11:8];
  wire [31:0] dest_val;
  wire [31:0] stack_val;
  wire [31:0] sh_res;
  wire sh_t;
  wire sh_twr;
  wire sh_rwr;
  wire sh_hit;
  wire t_bit = sw_r[`SW_T];

  wire op_flag_clear_op = (INSTR == `OP_FLAG_CLEAR);
  wire op_flag_set_op = (INSTR == `OP_FLAG_SET);
  wire op_accum_clear_op = (INSTR == `OP_ACCUM_CLEAR);
  wire op_udiv = (INSTR == `OP_UDIV_INIT);
  wire op_nop = (INSTR == `OP_NOP);
  wire op_rte = (INSTR == `OP_EXC_RETURN);
  wire op_rts = (INSTR == `OP_SUB_RETURN);
  wire op_sleep = (INSTR == `OP_SLEEP);
  wire op_jmp = is_n(INSTR, `GRP_FOUR, `LO_JUMP);
  wire op_jsr = is_n(INSTR, `GRP_FOUR, `LO_CALL);
  wire op_tas = is_n(INSTR, `GRP_FOUR, `LO_TEST_SET);
  wire op_flag_to_reg_op = is_n(INSTR, `GRP_ZERO, `LO_FLAG_TO_REG);

  // Store-control and store-system share one copy path
  reg st_hit;
  reg [31:0] st_val;
  always @* begin
    st_hit = 1'b1;
    st_val = 32'h00000000;
    if (INSTR[15:12] != `GRP_ZERO) begin
      st_hit = 1'b0;
    end else begin
      case (INSTR[7:0])
        `LO_ST_STATUS: st_val = sw_r;
        `LO_ST_GBASE: st_val = gbase_r;
        `LO_ST_VBASE: st_val = vbase_r;
        `LO_ST_MUL_ACC_HIGH: st_val = mul_acc_high_r;
        `LO_ST_MUL_ACC_LOW: st_val = mul_acc_low_r;
        `LO_ST_LINK: st_val = link_r;
        default: st_hit = 1'b0;
      endcase
    end
  end

  shift_unit u_shift (
    .op_hi(INSTR[15:12]),
    .op_lo(INSTR[7:0]),
    .val(dest_val),
    .t_in(t_bit),
    .res(sh_res),
    .t_out(sh_t),
    .t_wr(sh_twr),
    .r_wr(sh_rwr),
    .hit(sh_hit)
  );

  // ==========================================================
  // General register write port
  wire pop_sw_done = (state_r == S_POP_SW) & MEM_ACK;
  reg rf_we;
  reg [3:0] rf_wa;
  reg [31:0] rf_wd;
  always @* begin
    rf_we = 1'b0;
    rf_wa = dest;
    rf_wd = sh_res;
    if (pop_sw_done) begin
      rf_we = 1'b1;
      rf_wa = `STACK_REG;
      rf_wd = stack_val + 32'h00000008;
    end else if (accept) begin
      if (sh_hit & sh_rwr) begin
        rf_we = 1'b1;
      end else if (op_flag_to_reg_op) begin
        rf_we = 1'b1;
        rf_wd = {31'h00000000, t_bit};
      end else if (st_hit) begin
        rf_we = 1'b1;
        rf_wd = st_val;
      end
    end
  end

  gpr_file u_gpr (
    .clk(REF_CLK),
    .rstn(RSTN),
    .ra(dest),
    .rb(`STACK_REG),
    .we(rf_we),
    .wa(rf_wa),
    .wd(rf_wd),
    .qa(dest_val),
    .qb(stack_val)
  );

  // ==========================================================
  // AXI4-Lite slave
  reg awready_r;
  reg wready_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg arready_r;
  reg rvalid_r;
  reg [1:0] rresp_r;
  reg [31:0] rdata_r;
  reg [4:0] waddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  // Both halves of a write held and not yet answered
  wire wr_go = ~awready_r & ~wready_r & ~bvalid_r;
  wire wr_map = (waddr_r <= `ADDR_LINK) & (waddr_r != `ADDR_STAT);
  wire wake_wr = wr_go & (waddr_r == `ADDR_CTRL) & wstrb_r[0]
    & wdata_r[`CTRL_WAKE];

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      waddr_r <= 5'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h00000000;
    end else begin
      if (awready_r & S_AXI_AWVALID) begin
        awready_r <= 1'b0;
        waddr_r <= {S_AXI_AWADDR[4:2], 2'b00};
      end
      if (wready_r & S_AXI_WVALID) begin
        wready_r <= 1'b0;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_map ? `RESP_OKAY : `RESP_DECERR;
      end
      if (bvalid_r & S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
      if (arready_r & S_AXI_ARVALID) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rresp_r <= `RESP_OKAY;
        case ({S_AXI_ARADDR[4:2], 2'b00})
          `ADDR_CTRL: rdata_r <= ctrl_r & `CTRL_RESET;
          `ADDR_STAT: rdata_r <= {26'h0000000, sleep_r, ready_r,
            1'b0, state_r};
          `ADDR_SW: rdata_r <= sw_r;
          `ADDR_MUL_ACC_HIGH: rdata_r <= mul_acc_high_r;
          `ADDR_MUL_ACC_LOW: rdata_r <= mul_acc_low_r;
          `ADDR_GBASE: rdata_r <= gbase_r;
          `ADDR_VBASE: rdata_r <= vbase_r;
          `ADDR_LINK: rdata_r <= link_r;
          default: begin
            rdata_r <= 32'h00000000;
            rresp_r <= `RESP_DECERR;
          end
        endcase
      end
      if (rvalid_r & S_AXI_RREADY) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Execution sequencer and architectural registers
  wire run = ctrl_r[`CTRL_RUN];

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= S_IDLE;
      cnt_r <= 2'd0;
      ready_r <= 1'b0;
      sleep_pend_r <= 1'b0;
      sleep_r <= 1'b0;
      br_valid_r <= 1'b0;
      br_target_r <= 32'h00000000;
      unsup_r <= 1'b0;
      sw_r <= `SW_RESET;
      mul_acc_high_r <= 32'h00000000;
      mul_acc_low_r <= 32'h00000000;
      gbase_r <= 32'h00000000;
      vbase_r <= 32'h00000000;
      link_r <= 32'h00000000;
      ctrl_r <= `CTRL_RESET;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_byte_r <= 1'b0;
      mem_addr_r <= 32'h00000000;
      mem_wdata_r <= 32'h00000000;
      pop_pc_r <= 32'h00000000;
    end else begin
      br_valid_r <= 1'b0;
      unsup_r <= 1'b0;
      if (cnt_r != 2'd0) begin
        cnt_r <= cnt_r - 2'd1;
      end
      // Bus writes first so that a same-cycle core update wins
      if (wr_go & wr_map) begin
        case (waddr_r)
          `ADDR_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r)
            & `CTRL_RESET;
          `ADDR_SW: sw_r <= merge(sw_r, wdata_r, wstrb_r);
          `ADDR_MUL_ACC_HIGH: mul_acc_high_r <= merge(mul_acc_high_r, wdata_r, wstrb_r);
          `ADDR_MUL_ACC_LOW: mul_acc_low_r <= merge(mul_acc_low_r, wdata_r, wstrb_r);
          `ADDR_GBASE: gbase_r <= merge(gbase_r, wdata_r, wstrb_r);
          `ADDR_VBASE: vbase_r <= merge(vbase_r, wdata_r, wstrb_r);
          `ADDR_LINK: link_r <= merge(link_r, wdata_r, wstrb_r);
          default: ctrl_r <= ctrl_r;
        endcase
      end
      case (state_r)
        S_IDLE: begin
          ready_r <= run;
          if (accept) begin
            if (op_flag_clear_op) begin
              sw_r[`SW_T] <= 1'b0;
            end else if (op_flag_set_op) begin
              sw_r[`SW_T] <= 1'b1;
            end else if (op_accum_clear_op) begin
              mul_acc_high_r <= 32'h00000000;
              mul_acc_low_r <= 32'h00000000;
            end else if (op_udiv) begin
              sw_r[`SW_T] <= 1'b0;
              sw_r[`SW_Q] <= 1'b0;
              sw_r[`SW_M] <= 1'b0;
            end else if (op_nop) begin
              ready_r <= run;
            end else if (op_rts | op_jmp | op_jsr) begin
              br_valid_r <= 1'b1;
              br_target_r <= op_rts ? link_r : dest_val;
              if (op_jsr) begin
                link_r <= INSTR_PC + 32'h00000004;
              end
              ready_r <= 1'b0;
              cnt_r <= `STATES_BRANCH;
              state_r <= S_WAIT;
            end else if (op_rte) begin
              mem_req_r <= 1'b1;
              mem_we_r <= 1'b0;
              mem_byte_r <= 1'b0;
              mem_addr_r <= stack_val;
              ready_r <= 1'b0;
              cnt_r <= `STATES_EXC_RETURN;
              state_r <= S_POP_PC;
            end else if (op_sleep) begin
              sleep_pend_r <= 1'b1;
              ready_r <= 1'b0;
              cnt_r <= `STATES_SLEEP;
              state_r <= S_WAIT;
            end else if (op_tas) begin
              mem_req_r <= 1'b1;
              mem_we_r <= 1'b0;
              mem_byte_r <= 1'b1;
              mem_addr_r <= dest_val;
              ready_r <= 1'b0;
              cnt_r <= `STATES_TEST_SET;
              state_r <= S_TAS_RD;
            end else if (sh_hit) begin
              if (sh_twr) begin
                sw_r[`SW_T] <= sh_t;
              end
            end else if (!(op_flag_to_reg_op | st_hit)) begin
              // Outside these formats: flagged and retired as a no-op
              unsup_r <= 1'b1;
            end
          end
        end
        S_WAIT: begin
          if (cnt_r <= 2'd1) begin
            if (sleep_pend_r) begin
              sleep_pend_r <= 1'b0;
              sleep_r <= 1'b1;
              state_r <= S_SLEEP;
            end else begin
              ready_r <= run;
              state_r <= S_IDLE;
            end
          end
        end
        S_POP_PC: begin
          if (MEM_ACK) begin
            pop_pc_r <= MEM_RDATA;
            mem_addr_r <= mem_addr_r + 32'h00000004;
            state_r <= S_POP_SW;
          end
        end
        S_POP_SW: begin
          if (MEM_ACK) begin
            mem_req_r <= 1'b0;
            sw_r <= MEM_RDATA;
            br_valid_r <= 1'b1;
            br_target_r <= pop_pc_r;
            state_r <= S_WAIT;
          end
        end
        S_TAS_RD: begin
          if (MEM_ACK) begin
            sw_r[`SW_T] <= (MEM_RDATA[7:0] == 8'h00);
            mem_we_r <= 1'b1;
            mem_wdata_r <= {24'h000000, 1'b1, MEM_RDATA[6:0]};
            state_r <= S_TAS_WR;
          end
        end
        S_TAS_WR: begin
          if (MEM_ACK) begin
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            state_r <= S_WAIT;
          end
        end
        S_SLEEP: begin
          // Only a bus wake releases the core; no interrupt path here
          if (wake_wr) begin
            sleep_r <= 1'b0;
            ready_r <= run;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  assign INSTR_READY = ready_r;
  assign BRANCH_VALID = br_valid_r;
  assign BRANCH_TARGET = br_target_r;
  assign SLEEP = sleep_r;
  assign UNSUPPORTED = unsup_r;
  assign T_FLAG = sw_r[`SW_T];
  assign MEM_REQ = mem_req_r;
  assign MEM_WE = mem_we_r;
  assign MEM_BYTE = mem_byte_r;
  assign MEM_ADDR = mem_addr_r;
  assign MEM_WDATA = mem_wdata_r;
  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign S_AXI_RVALID = rvalid_r;
endmodule // cpu_zero_one_decode
`default_nettype wire

/* File: rtl/cpu_decode_regs.vh */
// Opcodes, status word layout, state counts and register offsets
`ifndef CPU_DECODE_REGS_VH
`define CPU_DECODE_REGS_VH
// Zero-operand opcodes
`define OP_FLAG_CLEAR 16'h0008
`define OP_FLAG_SET 16'h0018
`define OP_ACCUM_CLEAR 16'h0028
`define OP_UDIV_INIT 16'h0019
`define OP_NOP 16'h0009
`define OP_EXC_RETURN 16'h002B
`define OP_SUB_RETURN 16'h000B
`define OP_SLEEP 16'h001B
// Single-register groups and low bytes
`define GRP_ZERO 4'h0
`define GRP_FOUR 4'h4
`define LO_CMP_POS 8'h15
`define LO_CMP_NONNEG 8'h11
`define LO_DEC_TEST 8'h10
`define LO_ROT_LEFT 8'h04
`define LO_ROT_RIGHT 8'h05
`define LO_ROT_LEFT_T 8'h24
`define LO_ROT_RIGHT_T 8'h25
`define LO_ARITH_LEFT 8'h20
`define LO_ARITH_RIGHT 8'h21
`define LO_LOGIC_LEFT 8'h00
`define LO_LOGIC_RIGHT 8'h01
`define LO_SHL2 8'h08
`define LO_SHR2 8'h09
`define LO_SHL8 8'h18
`define LO_SHR8 8'h19
`define LO_SHL16 8'h28
`define LO_SHR16 8'h29
`define LO_JUMP 8'h2B
`define LO_CALL 8'h0B
`define LO_TEST_SET 8'h1B
// Group zero low bytes
`define LO_FLAG_TO_REG 8'h29
`define LO_ST_STATUS 8'h02
`define LO_ST_GBASE 8'h12
`define LO_ST_VBASE 8'h22
`define LO_ST_MUL_ACC_HIGH 8'h0A
`define LO_ST_MUL_ACC_LOW 8'h1A
`define LO_ST_LINK 8'h2A
// Status word bit positions
`define SW_T 0
`define SW_Q 8
`define SW_M 9
`define SW_RESET 32'h000000F0
// Execution state counts
`define STATES_EXC_RETURN 2'd3
`define STATES_BRANCH 2'd1
`define STATES_SLEEP 2'd2
`define STATES_TEST_SET 2'd3
`define STACK_REG 4'hF
// AXI4-Lite byte offsets
`define ADDR_CTRL 5'h00
`define ADDR_STAT 5'h04
`define ADDR_SW 5'h08
`define ADDR_MUL_ACC_HIGH 5'h0C
`define ADDR_MUL_ACC_LOW 5'h10
`define ADDR_GBASE 5'h14
`define ADDR_VBASE 5'h18
`define ADDR_LINK 5'h1C
`define CTRL_RUN 0
`define CTRL_WAKE 1
`define CTRL_RESET 32'h00000001
`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11
`endif

/* File: rtl/gpr_file.v */
// Sixteen general registers, two read ports and one write port
`timescale 1ns/1ps
`default_nettype none
module gpr_file (
  input wire clk,
  input wire rstn,
  input wire [3:0] ra,
  input wire [3:0] rb,
  input wire we,
  input wire [3:0] wa,
  input wire [31:0] wd,
  output wire [31:0] qa,
  output wire [31:0] qb
);
  reg [31:0] mem [0:15];
  integer i;

  assign qa = mem[ra];
  assign qb = mem[rb];

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < 16; i = i + 1) begin
        mem[i] <= 32'h00000000;
      end
    end else if (we) begin
      mem[wa] <= wd;
    end
  end
endmodule // gpr_file
`default_nettype wire

/* File: rtl/shift_unit.v */
// Compare, decrement-test, rotate and shift datapath for one register
`timescale 1ns/1ps
`default_nettype none
`include "cpu_decode_regs.vh"
module shift_unit (
  input wire [3:0] op_hi,
  input wire [7:0] op_lo,
  input wire [31:0] val,
  input wire t_in,
  output reg [31:0] res,
  output reg t_out,
  output reg t_wr,
  output reg r_wr,
  output reg hit
);
  always @* begin
    res = val;
    t_out = t_in;
    t_wr = 1'b1;
    r_wr = 1'b1;
    hit = (op_hi == `GRP_FOUR);
    case (op_lo)
      `LO_CMP_POS: begin
        t_out = ~val[31] & (|val);
        r_wr = 1'b0;
      end
      `LO_CMP_NONNEG: begin
        t_out = ~val[31];
        r_wr = 1'b0;
      end
      `LO_DEC_TEST: begin
        res = val - 32'h00000001;
        t_out = (val == 32'h00000001);
      end
      `LO_ROT_LEFT: begin
        res = {val[30:0], val[31]};
        t_out = val[31];
      end
      `LO_ROT_RIGHT: begin
        res = {val[0], val[31:1]};
        t_out = val[0];
      end
      `LO_ROT_LEFT_T: begin
        res = {val[30:0], t_in};
        t_out = val[31];
      end
      `LO_ROT_RIGHT_T: begin
        res = {t_in, val[31:1]};
        t_out = val[0];
      end
      `LO_ARITH_RIGHT: begin
        res = {val[31], val[31:1]};
        t_out = val[0];
      end
      `LO_ARITH_LEFT, `LO_LOGIC_LEFT: begin
        res = {val[30:0], 1'b0};
        t_out = val[31];
      end
      `LO_LOGIC_RIGHT: begin
        res = {1'b0, val[31:1]};
        t_out = val[0];
      end
      `LO_SHL2: begin
        res = {val[29:0], 2'b00};
        t_wr = 1'b0;
      end
      `LO_SHR2: begin
        res = {2'b00, val[31:2]};
        t_wr = 1'b0;
      end
      `LO_SHL8: begin
        res = {val[23:0], 8'h00};
        t_wr = 1'b0;
      end
      `LO_SHR8: begin
        res = {8'h00, val[31:8]};
        t_wr = 1'b0;
      end
      `LO_SHL16: begin
        res = {val[15:0], 16'h0000};
        t_wr = 1'b0;
      end
      `LO_SHR16: begin
        res = {16'h0000, val[31:16]};
        t_wr = 1'b0;
      end
      default: begin
        hit = 1'b0;
        t_wr = 1'b0;
        r_wr = 1'b0;
      end
    endcase
  end
endmodule // shift_unit
`default_nettype wire

/* File: verif/mem_model.sv */
// Far-side data memory answering the decoder's memory port
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic req,
  input wire logic we,
  input wire logic bsel,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output logic ack,
  output logic [31:0] rdata
);
  // ==========================================================
  // Storage and handshake
  logic [31:0] mem [16];
  logic [1:0] wait_r = 2'h0;
  logic [31:0] junk_r = 32'h5A5A5A5A;
  wire [31:0] word = mem[addr[5:2]];
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 32'h0;
    mem[2] = 32'h00000200;
    mem[3] = 32'h00000301;
  end
  // Prompt mode acks at once; slow adds two waits
  assign ack = req && (wait_r == (slow ? 2'h2 : 2'h0));
  // Outside an ack the data lines toggle so stale data never matches
  assign rdata = !ack ? junk_r : bsel ? {24'h0, word[8*addr[1:0] +: 8]} : word;
  always @(posedge clk) begin
    junk_r <= ~junk_r;
    wait_r <= ack ? 2'h0 : req ? wait_r + 2'h1 : 2'h0;
    if (ack && we && bsel) mem[addr[5:2]][8*addr[1:0] +: 8] <= wdata[7:0];
    else if (ack && we) mem[addr[5:2]] <= wdata;
  end
endmodule // mem_model
`default_nettype wire

/* File: verif/cpu_zero_one_decode_assertions.sv */
// Concurrent checks on the decoder's instruction and memory ports
`timescale 1ns/1ps
`default_nettype none
`include "cpu_decode_regs.vh"
module decode_checker (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR,
  input wire logic INSTR_READY,
  input wire logic BRANCH_VALID,
  input wire logic SLEEP,
  input wire logic T_FLAG,
  input wire logic MEM_REQ,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_ADDR
);
  // ==========================================================
  // Sequences and properties
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  wire tk = INSTR_VALID && INSTR_READY;
  wire g4 = tk && INSTR[15:12] == `GRP_FOUR;
  wire brk = tk && INSTR == `OP_SUB_RETURN
    || g4 && (INSTR[7:0] == `LO_JUMP || INSTR[7:0] == `LO_CALL);
  sequence br_seq;
    BRANCH_VALID && !INSTR_READY ##1 !BRANCH_VALID && INSTR_READY;
  endsequence
  sequence rte_seq;
    !INSTR_READY ##1 !INSTR_READY ##1 !INSTR_READY && BRANCH_VALID
    ##1 INSTR_READY;
  endsequence
  flag_clear_a:
    assert property (tk && INSTR == `OP_FLAG_CLEAR |=> !T_FLAG)
    else $error("T not 0");
  flag_set_a:
    assert property (tk && INSTR == `OP_FLAG_SET |=> T_FLAG)
    else $error("T not 1");
  accum_flag_a:
    assert property (tk && INSTR == `OP_ACCUM_CLEAR |=> $stable(T_FLAG))
    else $error("T moved");
  div_init_a:
    assert property (tk && INSTR == `OP_UDIV_INIT |=> !T_FLAG)
    else $error("T kept");
  nop_idle_a:
    assert property (tk && INSTR == `OP_NOP |=> $stable(T_FLAG) && INSTR_READY)
    else $error("nop effect");
  exc_return_a:
    assert property (tk && INSTR == `OP_EXC_RETURN |=> rte_seq)
    else $error("rte timing");
  branch_two_a:
    assert property (brk |=> br_seq)
    else $error("branch timing");
  sleep_entry_a:
    assert property (tk && INSTR == `OP_SLEEP |=> !SLEEP ##1 !SLEEP ##1 SLEEP)
    else $error("sleep timing");
  tas_start_a:
    assert property (g4 && INSTR[7:0] == `LO_TEST_SET |=> MEM_REQ && !INSTR_READY)
    else $error("tas no read");
  mem_hold_a:
    assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("mem req drop");
endmodule // decode_checker
bind cpu_zero_one_decode decode_checker chk (.*);
`default_nettype wire

/* File: verif/test_cpu_zero_one_decode.sv */
// Self-checking bench for the zero and one operand decoder
`timescale 1ns/1ps
`default_nettype none
`include "cpu_decode_regs.vh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module test_cpu_zero_one_decode;
  // ==========================================================
  // Signals and instances
  logic clk = 1'b0, rstn = 1'b0, iv = 1'b0, slow = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [15:0] ins = 16'h0009;
  logic [31:0] wdat = 32'h0, pc = 32'h00000100, dat;
  logic [4:0] awa = 5'h00, ara = 5'h00;
  logic [1:0] rsp;
  wire iry, bv, sl, tf, mrq, mwe, mby, mack, awr, wrd, bvl, arr, rvl, us;
  wire [31:0] bt, ma, mwd, mrd, rdd;
  wire [1:0] brs, rrs;
  int mismatches = 0, cmp_count = 0, n;
  logic [7:0] lo_t [20] = '{8'h04, 8'h05, 8'h24, 8'h25, 8'h21, 8'h01, 8'h20,
    8'h00, 8'h08, 8'h09, 8'h18, 8'h19, 8'h28, 8'h29, 8'h15, 8'h15, 8'h11,
    8'h11, 8'h10, 8'h10};
  logic [31:0] in_t [20] = '{32'h80000001, 32'h1, 32'h40000000, 32'h2,
    32'h80000003, 32'h80000003, 32'hC0000000, 32'h40000001, 32'h40000001,
    32'h12345678, 32'h12345678, 32'h12345678, 32'h12345678, 32'h12345678,
    32'h0, 32'h1, 32'h0, 32'h80000000, 32'h1, 32'h0};
  logic [31:0] out_t [20] = '{32'h3, 32'h80000000, 32'h80000001,
    32'h80000001, 32'hC0000001, 32'h40000001, 32'h80000000, 32'h80000002,
    32'h4, 32'h048D159E, 32'h34567800, 32'h00123456, 32'h56780000,
    32'h00001234, 32'h0, 32'h1, 32'h0, 32'h80000000, 32'h0, 32'hFFFFFFFF};
  // Bit 1 flag preset, bit 0 flag expected
  logic [1:0] tt [20] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h2,
    2'h3, 2'h0, 2'h3, 2'h0, 2'h3, 2'h0, 2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h2};
  cpu_zero_one_decode uut (.REF_CLK(clk), .RSTN(rstn), .INSTR_VALID(iv),
    .INSTR(ins), .INSTR_PC(pc), .INSTR_READY(iry), .BRANCH_VALID(bv),
    .BRANCH_TARGET(bt), .SLEEP(sl), .UNSUPPORTED(us), .T_FLAG(tf),
    .MEM_REQ(mrq), .MEM_WE(mwe), .MEM_BYTE(mby), .MEM_ADDR(ma),
    .MEM_WDATA(mwd), .MEM_ACK(mack), .MEM_RDATA(mrd),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdat), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(brs), .S_AXI_BVALID(bvl),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdd), .S_AXI_RRESP(rrs),
    .S_AXI_RVALID(rvl), .S_AXI_RREADY(rry));
  mem_model mem (.clk(clk), .slow(slow), .req(mrq), .we(mwe), .bsel(mby),
    .addr(ma), .wdata(mwd), .ack(mack), .rdata(mrd));
  always #12.5 clk = ~clk;
  // ==========================================================
  // Access tasks
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bit aw = 0, w = 0;
    @(posedge clk);
    awa <= a; wdat <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (awv && awr) begin aw = 1; awv <= 1'b0; end
      if (wv && wrd) begin w = 1; wv <= 1'b0; end
    end
    do @(posedge clk); while (!bvl);
    rsp = brs; bry <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rvl);
    dat = rdd; rsp = rrs; rry <= 1'b0;
  endtask
  // Counts states from the taking edge until ready again
  task automatic ex(input logic [15:0] op);
    @(posedge clk);
    ins <= op; iv <= 1'b1;
    do @(posedge clk); while (!iry);
    iv <= 1'b0; n = 1; #1;
    while (iry !== 1'b1 && n < 50) begin @(posedge clk); n++; #1; end
  endtask
  task automatic ld(input logic [3:0] r, input logic [31:0] v);
    wr(`ADDR_GBASE, v);
    ex({`GRP_ZERO, r, `LO_ST_GBASE});
  endtask
  task automatic gr(input logic [3:0] r, input logic [31:0] v);
    ex({`GRP_FOUR, r, `LO_JUMP});
    `CHK(bt, v)
    `CHK(n, 2)
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(`ADDR_CTRL); `CHK(dat, `CTRL_RESET)
    rd(`ADDR_SW); `CHK(dat, `SW_RESET)
    wr(`ADDR_STAT, 32'hFFFFFFFF); `CHK(rsp, `RESP_DECERR)
    ex(`OP_FLAG_SET); ex({`GRP_ZERO, 4'h6, `LO_ST_STATUS});
    gr(4'h6, 32'h000000F1);
    wr(`ADDR_SW, 32'h00000301); ex(`OP_UDIV_INIT);
    rd(`ADDR_SW); `CHK(dat, 32'h0)
    wr(`ADDR_MUL_ACC_HIGH, 32'h5); wr(`ADDR_MUL_ACC_LOW, 32'h6); ex(`OP_FLAG_SET);
    ex(`OP_ACCUM_CLEAR); `CHK(tf, 1'b1)
    rd(`ADDR_MUL_ACC_HIGH); `CHK(dat, 32'h0)
    rd(`ADDR_MUL_ACC_LOW); `CHK(dat, 32'h0)
    for (int i = 0; i < 20; i++) begin
      ld(i[3:0], in_t[i]);
      ex(tt[i][1] ? `OP_FLAG_SET : `OP_FLAG_CLEAR);
      ex({`GRP_FOUR, i[3:0], lo_t[i]});
      `CHK(tf, tt[i][0])
      `CHK(n, 1)
      gr(i[3:0], out_t[i]);
    end
    ex(`OP_FLAG_SET); ex({`GRP_ZERO, 4'h5, `LO_FLAG_TO_REG});
    gr(4'h5, 32'h1);
    ld(4'h3, 32'h00000400); ex({`GRP_FOUR, 4'h3, `LO_CALL});
    `CHK(bt, 32'h00000400)
    rd(`ADDR_LINK); `CHK(dat, 32'h00000104)
    ex(`OP_SUB_RETURN); `CHK(bt, 32'h00000104)
    `CHK(n, 2)
    ld(4'hF, 32'h8); ex(`OP_FLAG_CLEAR); ex(`OP_EXC_RETURN);
    `CHK(bt, 32'h00000200)
    `CHK(tf, 1'b1)
    `CHK(n, 4)
    ld(4'h4, 32'h10); ex({`GRP_FOUR, 4'h4, `LO_TEST_SET});
    `CHK(tf, 1'b1)
    `CHK(n, 4)
    @(posedge clk) slow <= 1'b1;
    ex({`GRP_FOUR, 4'h4, `LO_TEST_SET}); `CHK(tf, 1'b0)
    ex(`OP_NOP); `CHK(n, 1)
    ex(16'h0003); `CHK(us, 1'b1)
    ex(`OP_SLEEP); `CHK(sl, 1'b1)
    wr(`ADDR_CTRL, 32'h00000003); ex(`OP_NOP); `CHK(sl, 1'b0)
    complete_run;
  end
  initial begin
    #(25 * 20000);
    mismatches++;
    complete_run;
  end
endmodule // test_cpu_zero_one_decode
`default_nettype wire
